/* File: src/dps_store_unit.sv */
`timescale 1ns/1ns
`include "dps_defines.svh"
module dps_store_unit
#(
	parameter int PA_W = 48
)
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	input wire logic instr_valid,
	input wire logic [31:0] instr,
	input wire logic [63:0] base_value,
	input wire logic [63:0] second_value,
	input wire logic [63:0] float_value,
	output logic busy,
	output logic xlate_req,
	output logic [63:0] xlate_vaddr,
	input wire logic xlate_ack,
	input wire logic [63:0] xlate_paddr,
	input wire logic [2:0] xlate_cca,
	input wire dps_pkg::dps_xlate_fault_t xlate_fault,
	output dps_pkg::dps_mem_wr_t mem_wr,
	input wire logic mem_bus_err,
	output logic exc_valid,
	output dps_pkg::dps_cause_t exc_cause
);
	localparam logic [63:0] PA_MASK = {64{1'b1}} >> (64 - PA_W);

	// ----------------------------------------
	// state
	// ----------------------------------------
	dps_pkg::dps_state_t state_q, state_d;
	dps_pkg::dps_kind_t kind_q, kind_d;
	logic [63:0] va_q, va_d;
	logic [63:0] src_q, src_d;
	logic [63:0] pa_q, pa_d;
	logic [2:0] cca_q, cca_d;
	dps_pkg::dps_mem_wr_t wr_q, wr_d;
	dps_pkg::dps_cause_t exc_q, exc_d;
	logic exv_q, exv_d;
	logic req_q, req_d;
	logic [7:0] ctrl_q, ctrl_d;
	logic [8:0] st_q, st_d;
	logic [8:0] mask_q, mask_d;
	logic [31:0] rdata_q, rdata_d;
	logic irq_q, irq_d;
	logic busy_q, busy_d;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic dec_left, dec_right, dec_flt, dec_any;
	logic [63:0] ea_imm, ea_idx;
	logic fpu_ok, done;
	logic [2:0] bsel;
	logic [63:0] pa_part, pa_flt;

	// field layouts of the three stores
	always_comb
	begin
		dec_left = instr[31:26] == `DPS_OP_LEFT; // RULE15
		dec_right = instr[31:26] == `DPS_OP_RIGHT; // RULE1
		dec_flt = instr[31:26] == `DPS_OP_FPX && instr[10:6] == `DPS_ZERO5
			&& instr[5:0] == `DPS_FN_FSTORE; // RULE10
		dec_any = dec_left || dec_right || dec_flt;
		ea_imm = base_value + {{48{instr[15]}}, instr[15:0]}; // RULE2
		ea_idx = base_value + second_value; // RULE11
		fpu_ok = ctrl_q[`DPS_CTL_FPU] && ctrl_q[`DPS_CTL_COP1_EN]; // RULE13
	end

	// lane select and endian-adjusted physical addresses
	always_comb
	begin
		bsel = va_q[2:0] ^ {3{ctrl_q[`DPS_CTL_CPU_BE]}}; // RULE5
		pa_part = {xlate_paddr[63:3], xlate_paddr[2:0] ^ {3{ctrl_q[`DPS_CTL_FLIP]}}}; // RULE6
		if (!ctrl_q[`DPS_CTL_MEM_BE])
		begin
			pa_part[2:0] = 3'h0; // RULE6
		end
		pa_part = pa_part & PA_MASK;
		pa_flt = (xlate_paddr ^ {61'h0, ctrl_q[`DPS_CTL_CPU_BE] ^ ctrl_q[`DPS_CTL_FLIP], 2'h0})
			& PA_MASK; // RULE12
	end

	// ----------------------------------------
	// store sequencer
	// ----------------------------------------
	// faults other than bus errors are checked before any byte leaves, so a refused store never writes
	always_comb
	begin
		state_d = state_q;
		kind_d = kind_q;
		va_d = va_q;
		src_d = src_q;
		pa_d = pa_q;
		cca_d = cca_q;
		wr_d = wr_q;
		wr_d.valid = 1'b0;
		exc_d = '0;
		done = 1'b0;
		case (state_q)
			dps_pkg::DPS_IDLE:
			begin
				if (instr_valid && dec_any)
				begin
					if (ctrl_q[`DPS_CTL_REL6])
					begin
						exc_d.reserved_instr = 1'b1; // RULE9
					end
					else if (dec_flt && !fpu_ok)
					begin
						exc_d.cop_unusable = 1'b1; // RULE14
					end
					else if (dec_flt && ea_idx[2:0] != 3'h0)
					begin
						exc_d.addr_err = 1'b1; // RULE11
					end
					else
					begin
						state_d = dps_pkg::DPS_XLATE;
						kind_d = dec_flt ? dps_pkg::DPS_K_FLOAT
							: (dec_left ? dps_pkg::DPS_K_LEFT : dps_pkg::DPS_K_RIGHT);
						va_d = dec_flt ? ea_idx : ea_imm;
						src_d = dec_flt ? float_value : second_value;
					end
				end
			end
			dps_pkg::DPS_XLATE:
			begin
				if (xlate_ack)
				begin
					exc_d.tlb_refill = xlate_fault.refill; // RULE8
					exc_d.tlb_invalid = xlate_fault.invalid; // RULE8
					exc_d.tlb_mod = xlate_fault.modified; // RULE8
					exc_d.watch = xlate_fault.watch; // RULE14
					state_d = dps_pkg::DPS_IDLE;
					cca_d = xlate_cca;
					if (xlate_fault == '0)
					begin
						wr_d.valid = 1'b1;
						wr_d.vaddr = va_q;
						wr_d.cca = xlate_cca;
						case (kind_q)
							dps_pkg::DPS_K_LEFT:
							begin
								wr_d.addr = pa_part;
								wr_d.data = src_q >> (6'h38 - {bsel, 3'h0}); // RULE5
								wr_d.be = 8'hff >> (3'h7 - bsel); // RULE16
								done = 1'b1;
							end
							dps_pkg::DPS_K_RIGHT:
							begin
								wr_d.addr = pa_part;
								wr_d.data = src_q << {bsel, 3'h0}; // RULE7
								wr_d.be = 8'hff << bsel; // RULE3 RULE4 RULE16
								done = 1'b1;
							end
							default:
							begin
								// low word first at the adjusted address
								wr_d.addr = pa_flt;
								wr_d.data = {src_q[31:0], src_q[31:0]}; // RULE12
								wr_d.be = pa_flt[2] ? 8'hf0 : 8'h0f;
								pa_d = pa_flt ^ 64'h0000_0000_0000_0004;
								state_d = dps_pkg::DPS_WRHI;
							end
						endcase
					end
				end
			end
			dps_pkg::DPS_WRHI:
			begin
				wr_d.valid = 1'b1;
				wr_d.addr = pa_q;
				wr_d.vaddr = va_q + 64'h0000_0000_0000_0004; // RULE12
				wr_d.data = {src_q[63:32], src_q[63:32]};
				wr_d.be = pa_q[2] ? 8'hf0 : 8'h0f;
				wr_d.cca = cca_q;
				state_d = dps_pkg::DPS_IDLE;
				done = 1'b1;
			end
			default:
			begin
				state_d = dps_pkg::DPS_IDLE;
			end
		endcase
		exc_d.bus_err = mem_bus_err; // RULE8
		exv_d = exc_d != '0;
		req_d = state_d == dps_pkg::DPS_XLATE;
		busy_d = state_d != dps_pkg::DPS_IDLE;
	end

	// ----------------------------------------
	// register port and interrupt
	// ----------------------------------------
	// a read clears status, but an event in the same cycle survives it
	always_comb
	begin
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		st_d = st_q;
		rdata_d = 32'h0000_0000;
		if (reg_wr && reg_addr == `DPS_REG_CTRL)
		begin
			ctrl_d = reg_wdata[7:0];
		end
		if (reg_wr && reg_addr == `DPS_REG_MASK)
		begin
			mask_d = reg_wdata[8:0];
		end
		if (reg_rd)
		begin
			case (reg_addr)
				`DPS_REG_CTRL: rdata_d = {24'h00_0000, ctrl_q};
				`DPS_REG_STATUS: rdata_d = {23'h00_0000, st_q};
				`DPS_REG_MASK: rdata_d = {23'h00_0000, mask_q};
				`DPS_REG_STATE: rdata_d = {28'h000_0000, kind_q, state_q};
				default: rdata_d = 32'h0000_0000;
			endcase
			if (reg_addr == `DPS_REG_STATUS)
			begin
				st_d = 9'h000;
			end
		end
		st_d = st_d | {done, exc_d};
		irq_d = |(st_d & mask_d);
	end

	// all registers, synchronous active-low reset
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			state_q <= dps_pkg::DPS_IDLE;
			kind_q <= dps_pkg::DPS_K_LEFT;
			va_q <= 64'h0000_0000_0000_0000;
			src_q <= 64'h0000_0000_0000_0000;
			pa_q <= 64'h0000_0000_0000_0000;
			cca_q <= 3'h0;
			wr_q <= '0;
			exc_q <= '0;
			exv_q <= 1'b0;
			req_q <= 1'b0;
			ctrl_q <= `DPS_CTRL_RST;
			mask_q <= `DPS_MASK_RST;
			st_q <= 9'h000;
			rdata_q <= 32'h0000_0000;
			irq_q <= 1'b0;
			busy_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			kind_q <= kind_d;
			va_q <= va_d;
			src_q <= src_d;
			pa_q <= pa_d;
			cca_q <= cca_d;
			wr_q <= wr_d;
			exc_q <= exc_d;
			exv_q <= exv_d;
			req_q <= req_d;
			ctrl_q <= ctrl_d;
			mask_q <= mask_d;
			st_q <= st_d;
			rdata_q <= rdata_d;
			irq_q <= irq_d;
			busy_q <= busy_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq = irq_q;
	assign busy = busy_q;
	assign xlate_req = req_q;
	assign xlate_vaddr = va_q;
	assign mem_wr = wr_q;
	assign exc_valid = exv_q;
	assign exc_cause = exc_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	logic take_ok;
	assign take_ok = state_q == dps_pkg::DPS_XLATE && xlate_ack && xlate_fault == '0;

	property p_rel6_refuse;
		state_q == dps_pkg::DPS_IDLE && instr_valid && dec_any && ctrl_q[`DPS_CTL_REL6]
		|=> exc_valid && exc_cause.reserved_instr && !busy;
	endproperty
	a_rel6_refuse: assert property (p_rel6_refuse) else $error("release six store not refused"); // RULE9

	property p_misaligned;
		state_q == dps_pkg::DPS_IDLE && instr_valid && dec_flt && !ctrl_q[`DPS_CTL_REL6]
		&& fpu_ok && ea_idx[2:0] != 3'h0 |=> exc_valid && exc_cause.addr_err ##1 !mem_wr.valid;
	endproperty
	a_misaligned: assert property (p_misaligned) else $error("misaligned float store accepted"); // RULE11
	property p_no_fpu;
		state_q == dps_pkg::DPS_IDLE && instr_valid && dec_flt && !ctrl_q[`DPS_CTL_REL6]
		&& !fpu_ok |=> exc_cause.cop_unusable && !busy;
	endproperty
	a_no_fpu: assert property (p_no_fpu) else $error("float store without usable fpu"); // RULE13
	property p_right_lanes;
		take_ok && kind_q == dps_pkg::DPS_K_RIGHT |=> mem_wr.valid && mem_wr.be[7] && !busy;
	endproperty
	a_right_lanes: assert property (p_right_lanes) else $error("right store misses top lane"); // RULE4
	property p_left_lanes;
		take_ok && kind_q == dps_pkg::DPS_K_LEFT |=> mem_wr.valid && mem_wr.be[0] && !busy
		&& (mem_wr.be[1] || mem_wr.data == {56'h0, src_q[63:56]})
		&& (!mem_wr.be[7] || mem_wr.data == src_q);
	endproperty
	a_left_lanes: assert property (p_left_lanes) else $error("left store lane zero wrong"); // RULE5

	property p_float_pair;
		take_ok && kind_q == dps_pkg::DPS_K_FLOAT |=> mem_wr.valid ##1 mem_wr.valid
		&& mem_wr.vaddr == $past(mem_wr.vaddr) + 64'h0000_0000_0000_0004
		&& mem_wr.be == ~$past(mem_wr.be);
	endproperty
	a_float_pair: assert property (p_float_pair) else $error("float store word pair wrong"); // RULE12

	property p_little_mem;
		take_ok && kind_q != dps_pkg::DPS_K_FLOAT && !ctrl_q[`DPS_CTL_MEM_BE]
		|=> mem_wr.addr[2:0] == 3'h0;
	endproperty
	a_little_mem: assert property (p_little_mem) else $error("low address bits not cleared"); // RULE6

	property p_tlb_fault;
		state_q == dps_pkg::DPS_XLATE && xlate_ack && xlate_fault.refill
		|=> exc_valid && exc_cause.tlb_refill && !mem_wr.valid ##1 !mem_wr.valid;
	endproperty
	a_tlb_fault: assert property (p_tlb_fault) else $error("tlb refill did not block store"); // RULE8
endmodule : dps_store_unit

/* File: shared/dps_defines.svh */
`ifndef DPS_DEFINES_SVH
`define DPS_DEFINES_SVH
// Behaviour
// RULE1: opcode 101101 decodes right-part doubleword store
// RULE2: partial address is base plus signed offset
// RULE3: right store writes low one to eight bytes
// RULE4: right store lanes follow offset and endianness
// RULE5: left store right-justifies top source bytes
// RULE6: flip low physical bits, zero when little memory
// RULE7: right store shifts source left, zero fill
// RULE8: partial stores raise tlb, bus, address, watch faults; the code raises no address fault for them
// RULE9: release six mode rejects partial stores
// RULE10: decode indexed float store, function 001001
// RULE11: indexed address is base plus index, aligned
// RULE12: float store writes low word, then high word
// RULE13: float store needs fpu, either register mode
// RULE14: float store raises tlb, unusable, address, watch faults
// RULE15: opcode 101100 decodes left-part doubleword store
// RULE16: byte-enable mask leaves other bytes untouched
// ----------------------------------------
// instruction encodings
// ----------------------------------------
`define DPS_OP_LEFT 6'h2c
`define DPS_OP_RIGHT 6'h2d
`define DPS_OP_FPX 6'h13
`define DPS_FN_FSTORE 6'h09
`define DPS_ZERO5 5'h00
// ----------------------------------------
// register offsets
// ----------------------------------------
`define DPS_REG_CTRL 4'h0
`define DPS_REG_STATUS 4'h4
`define DPS_REG_MASK 4'h8
`define DPS_REG_STATE 4'hc
// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define DPS_CTL_MEM_BE 0
`define DPS_CTL_FLIP 1
`define DPS_CTL_CPU_BE 2
`define DPS_CTL_REL6 3
`define DPS_CTL_FPU 4
`define DPS_CTL_FR 5
`define DPS_CTL_COP1_EN 6
`define DPS_CTRL_RST 8'h55
`define DPS_MASK_RST 9'h000
`define DPS_ST_DONE 8
`endif

/* File: shared/dps_pkg.sv */
package dps_pkg;
	// ----------------------------------------
	// types shared by the store unit
	// ----------------------------------------
	typedef enum logic [1:0] {
		DPS_IDLE = 2'b00,
		DPS_XLATE = 2'b01,
		DPS_WRHI = 2'b10
	} dps_state_t;
	typedef enum logic [1:0] {
		DPS_K_LEFT = 2'b00,
		DPS_K_RIGHT = 2'b01,
		DPS_K_FLOAT = 2'b10
	} dps_kind_t;
	// bit 0 is tlb_refill, bit 7 is watch
	typedef struct packed {
		logic watch;
		logic cop_unusable;
		logic reserved_instr;
		logic addr_err;
		logic bus_err;
		logic tlb_mod;
		logic tlb_invalid;
		logic tlb_refill;
	} dps_cause_t;
	typedef struct packed {
		logic refill;
		logic invalid;
		logic modified;
		logic watch;
	} dps_xlate_fault_t;
	typedef struct packed {
		logic valid;
		logic [63:0] addr;
		logic [63:0] vaddr;
		logic [63:0] data;
		logic [7:0] be;
		logic [2:0] cca;
	} dps_mem_wr_t;
endpackage : dps_pkg

/* File: verification/dps_xlate_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// translation path model
// ----------------------------------------
module dps_xlate_model
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic xlate_req,
	input wire logic [63:0] xlate_vaddr,
	input wire logic [3:0] delay,
	input wire dps_pkg::dps_xlate_fault_t fault_cmd,
	output logic xlate_ack,
	output logic [63:0] xlate_paddr,
	output logic [2:0] xlate_cca,
	output dps_pkg::dps_xlate_fault_t xlate_fault
);
	logic [3:0] cnt_q;
	logic [63:0] map;
	// page remap keeps the low bits; answers are garbled outside the ack cycle
	assign map = xlate_vaddr ^ 64'h0000_0000_0040_0000;
	assign xlate_paddr = xlate_ack ? map : ~map;
	assign xlate_cca = xlate_ack ? 3'h5 : 3'h2;
	assign xlate_fault = xlate_ack ? fault_cmd : ~fault_cmd;
	// one ack pulse after delay plus one cycles of request, so prompt and slow answers both occur
	always_ff @(posedge clock)
	begin
		if (!rst_b || xlate_ack || !xlate_req)
		begin
			xlate_ack <= 1'b0;
			cnt_q <= 4'h0;
		end
		else if (cnt_q == delay)
			xlate_ack <= 1'b1;
		else
			cnt_q <= cnt_q + 4'h1;
	end
endmodule : dps_xlate_model

/* File: verification/doubleword_partial_store_unit_bench.sv */
`timescale 1ns/1ns
`include "dps_defines.svh"
module doubleword_partial_store_unit_bench;
	localparam logic [31:0] RT = {`DPS_OP_RIGHT, 10'h022, 16'hfff8};
	localparam logic [31:0] FL = {`DPS_OP_FPX, 15'h0443, 5'h00, `DPS_FN_FSTORE};
	localparam logic [63:0] SRC = 64'h0102_0304_0506_0708;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic instr_valid = 1'b0;
	logic mem_bus_err = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [3:0] delay = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] instr = 32'h0;
	logic [31:0] reg_rdata, rd;
	logic [63:0] base_value = 64'h0;
	logic [63:0] second_value = 64'h0;
	logic [63:0] float_value = 64'h0;
	logic [63:0] xlate_vaddr, xlate_paddr, va, pa;
	logic irq, busy, xlate_req, xlate_ack, exc_valid;
	logic [2:0] xlate_cca;
	logic [7:0] exc_q;
	dps_pkg::dps_xlate_fault_t xlate_fault;
	dps_pkg::dps_xlate_fault_t fault_cmd = 4'h0;
	dps_pkg::dps_mem_wr_t mem_wr;
	dps_pkg::dps_mem_wr_t wq[$];
	dps_pkg::dps_cause_t exc_cause;
	int fail_count = 0;
	int check_count = 0;
	int cyc = 0;
	int nexc = 0;
	always #5 clock = ~clock;
	dps_store_unit #(.PA_W(48)) dut_u (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.irq, .instr_valid, .instr, .base_value, .second_value, .float_value, .busy, .xlate_req, .xlate_vaddr,
		.xlate_ack, .xlate_paddr, .xlate_cca, .xlate_fault, .mem_wr, .mem_bus_err, .exc_valid, .exc_cause);
	dps_xlate_model model_u (.clock, .rst_b, .xlate_req, .xlate_vaddr, .delay, .fault_cmd, .xlate_ack,
		.xlate_paddr, .xlate_cca, .xlate_fault);
	// ----------------------------------------
	// capture and helpers
	// ----------------------------------------
	// pulses stand one cycle, so they are taken at the edge that ends it
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (mem_wr.valid === 1'b1)
			wq.push_back(mem_wr);
		if (exc_valid === 1'b1)
		begin
			exc_q = exc_cause;
			nexc++;
		end
		if (cyc == 20000)
		begin
			fail_count++;
			final_report();
		end
	end
	task automatic chk(input logic [255:0] got, input logic [255:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rw(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : rw
	task automatic rr(input logic [3:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rr
	task automatic op(input logic [31:0] i, input logic [63:0] b, s, f, input int hold, nw, ne);
		wq.delete();
		nexc = 0;
		@(posedge clock);
		instr <= i;
		base_value <= b;
		second_value <= s;
		float_value <= f;
		instr_valid <= 1'b1;
		repeat (hold) @(posedge clock);
		instr_valid <= 1'b0;
		repeat (40)
		begin
			@(posedge clock);
			#1;
			if (busy === 1'b0 && wq.size() == nw && nexc == ne)
				break;
		end
		chk(wq.size(), nw);
		chk(nexc, ne);
	endtask : op
	// expected partial write, worked out from the address and mode bits
	function automatic dps_pkg::dps_mem_wr_t ew(input logic r, input logic [63:0] v, s, input logic [7:0] c);
		logic [2:0] k;
		ew.valid = 1'b1;
		ew.vaddr = v;
		ew.cca = 3'h5;
		ew.addr = (v ^ 64'h0000_0000_0040_0000) & 64'h0000_ffff_ffff_ffff;
		ew.addr[2:0] = (v[2:0] ^ {3{c[`DPS_CTL_FLIP]}}) & {3{c[`DPS_CTL_MEM_BE]}};
		k = v[2:0] ^ {3{c[`DPS_CTL_CPU_BE]}};
		ew.data = r ? s << (8 * k) : s >> (56 - 8 * k);
		ew.be = r ? 8'hff << k : 8'hff >> (7 - k);
	endfunction : ew
	task automatic ex(input logic [7:0] c, input logic [31:0] i, input logic [63:0] x, input logic [3:0] f,
		input logic [7:0] e);
		rw(`DPS_REG_CTRL, {24'h0, c});
		fault_cmd <= f;
		op(i, 64'h2000, x, SRC, 1, 0, 1);
		chk(exc_q, e);
		fault_cmd <= 4'h0;
	endtask : ex
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		rr(`DPS_REG_CTRL, rd);
		chk(rd, 32'h0000_0055);
		chk({busy, irq, exc_valid, xlate_req, mem_wr.valid}, 5'h00);
		rr(`DPS_REG_MASK, rd);
		chk(rd, 32'h0);
		rr(`DPS_REG_STATUS, rd);
		chk(rd, 32'h0);
		rr(`DPS_REG_STATE, rd);
		chk(rd, 32'h0);
		rr(4'h2, rd);
		chk(rd, 32'h0);
	endtask : t_reset
	// every offset, both partial kinds, four mode mixes, then the float store
	task automatic t_stores();
		logic [7:0] cl[4] = '{8'h55, 8'h51, 8'h52, 8'h77};
		foreach (cl[n])
		begin
			rw(`DPS_REG_CTRL, {24'h0, cl[n]});
			rr(`DPS_REG_CTRL, rd);
			chk(rd, {24'h0, cl[n]});
			for (int k = 0; k < 16; k++)
			begin
				va = 64'hffff_0000_0001_2340 + k[2:0];
				op({k < 8 ? `DPS_OP_RIGHT : `DPS_OP_LEFT, RT[25:0]}, va + 64'h8, SRC, 64'h0, 1, 1, 0);
				chk(wq[0], ew(k < 8, va, SRC, cl[n]));
			end
			va = 64'hffff_0000_0001_2340;
			op(FL, va - 64'h8, 64'h8, SRC, 1, 2, 0);
			pa = (va ^ 64'h0000_0000_0040_0000) & 64'h0000_ffff_ffff_ffff;
			pa[2] = cl[n][`DPS_CTL_CPU_BE] ^ cl[n][`DPS_CTL_FLIP];
			chk(wq[0], {1'b1, pa, va, {2{SRC[31:0]}}, pa[2] ? 8'hf0 : 8'h0f, 3'h5});
			chk(wq[1], {1'b1, pa ^ 64'h4, va + 64'h4, {2{SRC[63:32]}}, pa[2] ? 8'h0f : 8'hf0, 3'h5});
		end
	endtask : t_stores
	task automatic t_exc();
		ex(8'h55, FL, 64'h9, 4'h0, 8'h10);
		ex(8'h5d, RT, 64'h0, 4'h0, 8'h20);
		ex(8'h5d, FL, 64'h8, 4'h0, 8'h20);
		ex(8'h15, FL, 64'h8, 4'h0, 8'h40);
		ex(8'h55, FL, 64'h8, 4'h8, 8'h01);
		ex(8'h55, RT, 64'h0, 4'h8, 8'h01);
		ex(8'h55, RT, 64'h0, 4'h4, 8'h02);
		ex(8'h55, RT, 64'h0, 4'h2, 8'h04);
		ex(8'h55, RT, 64'h0, 4'h1, 8'h80);
		op(FL | 32'h0000_0040, 64'h2000, 64'h8, SRC, 1, 0, 0);
		nexc = 0;
		@(posedge clock);
		mem_bus_err <= 1'b1;
		@(posedge clock);
		mem_bus_err <= 1'b0;
		repeat (4) @(posedge clock);
		#1 chk({nexc[3:0], exc_q}, 12'h1_08);
	endtask : t_exc
	// the done bit is masked away; only the address fault may raise the line
	task automatic t_irq();
		rw(`DPS_REG_MASK, 32'h0000_0010);
		rr(`DPS_REG_STATUS, rd);
		op(RT, 64'h2000, SRC, SRC, 1, 1, 0);
		rr(`DPS_REG_STATUS, rd);
		chk({irq, rd}, 33'h0_0000_0100);
		ex(8'h55, FL, 64'h9, 4'h0, 8'h10);
		repeat (2) @(posedge clock);
		#1 chk(irq, 1'b1);
		rr(`DPS_REG_STATUS, rd);
		chk(rd, 32'h0000_0010);
		@(posedge clock);
		#1 chk(irq, 1'b0);
		rw(`DPS_REG_MASK, 32'h0);
		ex(8'h55, FL, 64'h9, 4'h0, 8'h10);
		repeat (2) @(posedge clock);
		#1 chk(irq, 1'b0);
	endtask : t_irq
	// slow translation; offers made while busy must be dropped
	task automatic t_busy();
		delay <= 4'h4;
		// the state register is read while translation is still pending
		fork
			op(RT, 64'h2000, SRC, SRC, 3, 1, 0);
			begin
				repeat (3) @(posedge clock);
				rr(`DPS_REG_STATE, rd);
			end
		join
		chk(rd, {28'h000_0000, dps_pkg::DPS_K_RIGHT, dps_pkg::DPS_XLATE});
		chk(wq[0], ew(1'b1, 64'h1ff8, SRC, 8'h55));
		delay <= 4'h0;
	endtask : t_busy
	task automatic final_report();
		$display("mismatches %0d comparisons %0d", fail_count, check_count);
		if (fail_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report
	initial
	begin
		repeat (4) @(posedge clock);
		rst_b <= 1'b1;
		t_reset();
		t_stores();
		t_exc();
		t_irq();
		t_busy();
		final_report();
	end
endmodule : doubleword_partial_store_unit_bench
